// ### rtl/eoq_pkg.sv
// Constants and types shared by the event output qualifier block.
// Assumes a single 50 MHz clock and an APB master with 32-bit data.
`default_nettype none
package eoq_pkg;
  // Clock and one-second timebase; the cycle count is derived from the times.
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SECOND_NS     = 1000000000;
  localparam int unsigned TICK_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 26;
  // Channel count: event relays one to three, then discrete outputs one to five.
  localparam int unsigned NCH           = 8;
  localparam int unsigned NLOGIC        = 6;  // Channels that may run the two-input logic.
  localparam int unsigned TC_FIRST      = 6;  // First channel with timer/counter.
  localparam int unsigned NDI           = 10;
  localparam int unsigned NTS           = 8;
  // Register byte offsets.
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [2:0] BLK_CFG        = 3'h1;  // 0x20 + 4*channel.
  localparam logic [2:0] BLK_LOGIC      = 3'h2;  // 0x40 + 4*channel.
  // Status field positions.
  localparam int unsigned ST_DI_LSB     = 0;
  localparam int unsigned ST_OUT_LSB    = 10;
  localparam int unsigned ST_RUN_BIT    = 18;
  // Limits of the settings.
  localparam logic [13:0] DELAY_MAX     = 14'h270f;  // 9999 s.
  localparam logic [12:0] COUNT_MAX     = 13'h1388;  // 5000 s or counts.
  localparam logic [4:0]  OT_MAX        = 5'h1c;
  // Output type codes.
  localparam logic [4:0]  OT_NONE       = 5'h01;
  localparam logic [4:0]  OT_LIMIT_LO   = 5'h02;
  localparam logic [4:0]  OT_LIMIT_HI   = 5'h07;
  localparam logic [4:0]  OT_LOGIC      = 5'h0c;
  localparam logic [4:0]  OT_POS_HI     = 5'h1a;
  localparam logic [4:0]  OT_POS_LO     = 5'h1b;
  // Suppression settings.
  localparam logic [1:0]  SUP_OFF       = 2'h0;
  localparam logic [1:0]  SUP_RUN       = 2'h1;
  localparam logic [1:0]  SUP_SETPOINT  = 2'h2;
  localparam logic [1:0]  SUP_OVF_OFF   = 2'h3;
  // Logic functions; on timer/counter channels bit 0 picks the counter.
  localparam logic [1:0]  FN_AND        = 2'h0;
  localparam logic [1:0]  FN_OR         = 2'h1;
  localparam logic [1:0]  FN_XOR        = 2'h2;
  // Input conditioners.
  localparam logic [1:0]  CND_PASS      = 2'h0;
  localparam logic [1:0]  CND_COMPLEMENT = 2'h1;
  localparam logic [1:0]  CND_TOGGLE    = 2'h2;
  // Source codes: 0 none, 1..8 program time signals, 9..18 contact inputs.
  localparam logic [4:0]  SRC_TS_LO     = 5'h01;
  localparam logic [4:0]  SRC_TS_HI     = 5'h08;
  localparam logic [4:0]  SRC_DI_LO     = 5'h09;
  localparam logic [4:0]  SRC_DI_HI     = 5'h12;
  // Channel configuration word, occupying bits 21:0.
  localparam int unsigned CCFG_W        = 22;
  typedef struct packed {
    logic [13:0] assert_delay;         // 0 disables the delay.
    logic [1:0]  power_on_suppress;    // Suppression setting.
    logic        output_polarity;      // 1 selects normally-closed.
    logic [4:0]  output_type_select;   // Output type code.
  } eoq_chan_cfg_s;
  // Logic configuration word, occupying bits 28:0.
  localparam int unsigned LCFG_W        = 29;
  typedef struct packed {
    logic [12:0] preset;               // Timer seconds or counter target, 0 off.
    logic [1:0]  input_conditioner_b;
    logic [1:0]  input_conditioner_a;
    logic [4:0]  logic_source_b;
    logic [4:0]  logic_source_a;
    logic [1:0]  logic_function_select;
  } eoq_logic_cfg_s;
  localparam eoq_chan_cfg_s  CCFG_RESET = '{assert_delay: 14'h0000, power_on_suppress: SUP_OFF,
                                            output_polarity: 1'b0, output_type_select: OT_NONE};
  localparam eoq_logic_cfg_s LCFG_RESET = '{default: '0};
  // Timer state codes.
  typedef enum logic [1:0] {
    TC_IDLE   = 2'b01,
    TC_TIMING = 2'b10
  } eoq_tc_state_e;
endpackage
`default_nettype wire

// ### rtl/eoq_qualifier.sv
// Event and discrete output qualifier with its APB register file.
// Assumes inputs synchronous to ref_clk_in and contact inputs held stable for 0.1 s.
`default_nettype none
// Behaviour
// - Output asserts after source persists delay seconds.
// - Source loss clears delay; recurrence restarts count.
// - Delay off: output follows source directly.
// - New delay compares against already elapsed time.
// - Delay and suppression only for types 2-7.
// - Suppressed output waits for range exit, re-entry.
// - Suppress 1: power-up, run; 2: also setpoint.
// - Suppress 3: no suppression, overflow forces off.
// - Suppress off/1/2: overflow forces output on.
// - Two-input logic only on first six channels.
// - Logic function AND, OR or XOR, AND default.
// - Sources: none, time signal 1-8, contact 1-10.
// - Shared contact inputs; none source never triggers.
// - Timer and counter only on last two outputs.
// - Timer/counter ignore run state; one-second pulse.
// - Timer preset off or 1-5000 seconds.
// - Counter target off or 1-5000 counts.
// - Timer fires after time; counter at target.
// - Status shows every contact input's live state.
// - Contact input one fixed to run/reset.
// - Polarity: normally-open or normally-closed output drive.
// - Limit and position types off in reset state.
module eoq_qualifier
  import eoq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF  // Clock cycles per second.
)
(
  input  wire logic            ref_clk_in,             // 50 MHz clock.
  input  wire logic            rst_n_in,               // Synchronous reset, active low.
  input  wire logic [7:0]      paddr_in,               // APB byte address.
  input  wire logic            psel_in,                // APB select.
  input  wire logic            penable_in,             // APB enable.
  input  wire logic            pwrite_in,              // APB direction, high for write.
  input  wire logic [31:0]     pwdata_in,              // APB write data.
  output logic [31:0]          prdata_out,             // APB read data.
  output logic                 pready_out,             // APB ready.
  output logic                 pslverr_out,            // APB error.
  input  wire logic [NDI-1:0]  contact_input_in,       // Contact inputs, bit 0 is run/reset.
  input  wire logic [NTS-1:0]  program_time_signal_in, // Program time signals.
  input  wire logic [NCH-1:0]  action_range_in,        // Measured value inside action range.
  input  wire logic [NCH-1:0]  range_overflow_in,      // Range overflow on monitored input.
  input  wire logic            setpoint_change_in,     // One-cycle pulse on setpoint change.
  output logic [NCH-1:0]       output_pin_out,         // Contact or transistor drive.
  output logic                 run_state_out           // High while running.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Picks the raw level of a source code; unknown codes and none give zero.
  function automatic logic src_pick(input logic [4:0] src, input logic [NTS-1:0] ts,
                                    input logic [NDI-1:0] di);
    logic       v;
    logic [4:0] k;
    v = 1'b0;
    k = 5'h00;
    if (src >= SRC_TS_LO && src <= SRC_TS_HI)
    begin
      k = src - SRC_TS_LO;
      v = ts[k[2:0]];
    end
    else if (src >= SRC_DI_LO && src <= SRC_DI_HI)
    begin
      k = src - SRC_DI_LO;
      v = di[k[3:0]];
    end
    return v;
  endfunction

  // True for program time signal codes.
  function automatic logic is_ts(input logic [4:0] src);
    return (src >= SRC_TS_LO) && (src <= SRC_TS_HI);
  endfunction

  // Applies a conditioner to a raw level or its stored toggle bit.
  function automatic logic condition(input logic [1:0] cnd, input logic [4:0] src,
                                     input logic raw, input logic tog);
    logic v;
    v = raw;
    if (cnd == CND_COMPLEMENT)
    begin
      v = ~raw;
    end
    else if (cnd == CND_TOGGLE)
    begin
      v = tog;
    end
    if (src == 5'h00)
    begin
      v = 1'b0;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage and bus slave.

  eoq_chan_cfg_s  ccfg   [NCH];       // Per-channel output configuration.
  eoq_logic_cfg_s lcfg   [NCH];       // Per-channel logic and timer configuration.
  logic [NCH-1:0] asserted;           // Qualified event state before polarity.
  logic           run_q;              // Controller run state.
  logic           setup;              // Setup phase of a transfer.
  logic           access;             // Completing access phase.
  logic [2:0]     blk;                // Address block.
  logic [2:0]     idx;                // Channel index from the address.
  logic           bad;                // Transfer to be refused.
  logic [31:0]    rdata;              // Read data for the addressed register.
  eoq_chan_cfg_s  wc;                 // Write data seen as a channel word.
  eoq_logic_cfg_s wl;                 // Write data seen as a logic word.

  assign setup  = psel_in & ~penable_in;
  assign access = psel_in & penable_in & pready_out;
  assign blk    = paddr_in[7:5];
  assign idx    = paddr_in[4:2];
  assign wc     = eoq_chan_cfg_s'(pwdata_in[CCFG_W-1:0]);
  assign wl     = eoq_logic_cfg_s'(pwdata_in[LCFG_W-1:0]);

  // Decodes the address and checks write data; bad settings are refused whole.
  always_comb
  begin
    bad   = 1'b0;
    rdata = 32'h0000_0000;
    if (paddr_in[1:0] != 2'h0)
    begin
      bad = 1'b1;
    end
    else if (paddr_in == ADDR_STATUS)
    begin
      // Status is read-only.
      bad = pwrite_in;
      rdata[ST_DI_LSB +: NDI]  = contact_input_in;
      rdata[ST_OUT_LSB +: NCH] = asserted;
      rdata[ST_RUN_BIT]        = run_q;
    end
    else if (blk == BLK_CFG)
    begin
      rdata[CCFG_W-1:0] = ccfg[idx];
      if (pwrite_in && (wc.assert_delay > DELAY_MAX || wc.output_type_select > OT_MAX))
      begin
        bad = 1'b1;
      end
    end
    else if (blk == BLK_LOGIC)
    begin
      rdata[LCFG_W-1:0] = lcfg[idx];
      if (pwrite_in)
      begin
        if ((wl.input_conditioner_a == CND_TOGGLE && is_ts(wl.logic_source_a)) ||
            (wl.input_conditioner_b == CND_TOGGLE && is_ts(wl.logic_source_b)))
        begin
          bad = 1'b1;
        end
        if (wl.preset > COUNT_MAX || wl.logic_source_a > SRC_DI_HI ||
            wl.logic_source_b > SRC_DI_HI || wl.logic_function_select > FN_XOR)
        begin
          bad = 1'b1;
        end
      end
    end
    else
    begin
      // Unmapped addresses answer with an error and read zero.
      bad = 1'b1;
    end
  end

  // Answers every transfer after one access cycle; data is captured at setup.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end
    else
    begin
      pready_out  <= setup;
      pslverr_out <= setup & bad;
      prdata_out  <= (setup && !pwrite_in) ? rdata : 32'h0000_0000;
    end
  end

  // Stores accepted writes; refused writes leave the registers untouched.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int n = 0; n < NCH; n++)
      begin
        ccfg[n] <= CCFG_RESET;
        lcfg[n] <= LCFG_RESET;
      end
    end
    else if (access && pwrite_in && !pslverr_out)
    begin
      if (blk == BLK_CFG)
      begin
        ccfg[idx] <= wc;
      end
      else if (blk == BLK_LOGIC)
      begin
        lcfg[idx] <= wl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-second timebase and run/reset switching.

  logic [TICK_W-1:0] tick_cnt_q;      // Cycles within the current second.
  logic              tick;            // One-cycle pulse each second.
  logic              di1_prev_q;      // Previous run/reset contact level.
  logic              run_rise;        // Reset-to-run transition this cycle.

  assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

  // Free-running second counter shared by every channel.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      tick_cnt_q <= '0;
    end
    else
    begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      di1_prev_q <= 1'b0;
      run_q      <= 1'b0;
    end
    else
    begin
      di1_prev_q <= contact_input_in[0];
      // The switch acts on its closing edge, so a held contact does not chatter.
      if (contact_input_in[0] && !di1_prev_q)
      begin
        run_q <= ~run_q;
      end
    end
  end

  assign run_rise = contact_input_in[0] & ~di1_prev_q & ~run_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Input conditioning and two-input logic.

  logic [1:0] raw        [NCH];       // Raw selected sources a and b.
  logic [1:0] raw_prev_q [NCH];       // Previous raw sources for edge detection.
  logic [1:0] tog_q      [NCH];       // Toggle latches.
  logic [1:0] cnd        [NCH];       // Conditioned inputs.
  logic [NCH-1:0] logic_val;          // Two-input logic result.

  always_comb
  begin
    for (int n = 0; n < NCH; n++)
    begin
      raw[n][0] = src_pick(lcfg[n].logic_source_a, program_time_signal_in, contact_input_in);
      raw[n][1] = src_pick(lcfg[n].logic_source_b, program_time_signal_in, contact_input_in);
      cnd[n][0] = condition(lcfg[n].input_conditioner_a, lcfg[n].logic_source_a,
                            raw[n][0], tog_q[n][0]);
      cnd[n][1] = condition(lcfg[n].input_conditioner_b, lcfg[n].logic_source_b,
                            raw[n][1], tog_q[n][1]);
      case (lcfg[n].logic_function_select)
        FN_OR:   logic_val[n] = cnd[n][0] | cnd[n][1];
        FN_XOR:  logic_val[n] = cnd[n][0] ^ cnd[n][1];
        default: logic_val[n] = cnd[n][0] & cnd[n][1];
      endcase
    end
  end

  // Toggle latches flip on each rising edge of their raw source.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int n = 0; n < NCH; n++)
      begin
        raw_prev_q[n] <= 2'h0;
        tog_q[n]      <= 2'h0;
      end
    end
    else
    begin
      for (int n = 0; n < NCH; n++)
      begin
        raw_prev_q[n] <= raw[n];
        tog_q[n]      <= tog_q[n] ^ (raw[n] & ~raw_prev_q[n]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timer and counter on the last two discrete outputs.

  eoq_tc_state_e     tc_state_q [2];  // Timer state.
  logic [12:0]       tc_cnt_q   [2];  // Elapsed seconds or counted edges.
  logic [1:0]        tc_prev_q;       // Previous conditioned input.
  logic [1:0]        pulse_q;         // One-second output pulse.
  logic [TICK_W-1:0] pulse_cnt_q [2]; // Cycles left in the pulse.

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      tc_prev_q <= 2'h0;
      pulse_q   <= 2'h0;
      for (int j = 0; j < 2; j++)
      begin
        tc_state_q[j]  <= TC_IDLE;
        tc_cnt_q[j]    <= 13'h0000;
        pulse_cnt_q[j] <= '0;
      end
    end
    else
    begin
      for (int j = 0; j < 2; j++)
      begin
        automatic logic       in_now = cnd[TC_FIRST + j][0];
        automatic logic       rise   = in_now & ~tc_prev_q[j];
        automatic logic [12:0] preset = lcfg[TC_FIRST + j].preset;
        automatic logic       fire   = 1'b0;
        tc_prev_q[j] <= in_now;
        if (lcfg[TC_FIRST + j].logic_function_select[0])
        begin
          tc_state_q[j] <= TC_IDLE;
          if (rise && preset != 13'h0000)
          begin
            if (tc_cnt_q[j] + 13'h0001 >= preset)
            begin
              fire         = 1'b1;
              tc_cnt_q[j] <= 13'h0000;
            end
            else
            begin
              tc_cnt_q[j] <= tc_cnt_q[j] + 13'h0001;
            end
          end
        end
        else
        begin
          case (tc_state_q[j])
            TC_IDLE:
            begin
              if (rise && preset != 13'h0000)
              begin
                tc_state_q[j] <= TC_TIMING;
                tc_cnt_q[j]   <= 13'h0000;
              end
            end
            TC_TIMING:
            begin
              if (preset == 13'h0000)
              begin
                tc_state_q[j] <= TC_IDLE;
              end
              else if (tick)
              begin
                if (tc_cnt_q[j] + 13'h0001 >= preset)
                begin
                  fire           = 1'b1;
                  tc_state_q[j] <= TC_IDLE;
                end
                tc_cnt_q[j] <= tc_cnt_q[j] + 13'h0001;
              end
            end
            default:
            begin
              tc_state_q[j] <= TC_IDLE;
            end
          endcase
        end
        if (fire)
        begin
          pulse_q[j]     <= 1'b1;
          pulse_cnt_q[j] <= TICK_W'(TICK_CYCLES - 1);
        end
        else if (pulse_cnt_q[j] != '0)
        begin
          pulse_cnt_q[j] <= pulse_cnt_q[j] - 1'b1;
        end
        else
        begin
          pulse_q[j] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertion delay and suppression for limit types.

  logic [13:0]    elapsed_q [NCH];    // Seconds since the source arose.
  logic [NCH-1:0] inhibit_q;          // Suppression armed.
  logic [NCH-1:0] next_asserted;      // Qualified event state.

  // Elapsed time kept across setting changes
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int n = 0; n < NCH; n++)
      begin
        elapsed_q[n] <= 14'h0000;
      end
    end
    else
    begin
      for (int n = 0; n < NCH; n++)
      begin
        if (!action_range_in[n])
        begin
          elapsed_q[n] <= 14'h0000;
        end
        else if (tick && elapsed_q[n] < DELAY_MAX)
        begin
          elapsed_q[n] <= elapsed_q[n] + 14'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      inhibit_q <= {NCH{1'b1}};
    end
    else
    begin
      for (int n = 0; n < NCH; n++)
      begin
        automatic logic [1:0] s = ccfg[n].power_on_suppress;
        automatic logic arm = ((s == SUP_RUN || s == SUP_SETPOINT) && run_rise) ||
                              (s == SUP_SETPOINT && setpoint_change_in);
        if (arm)
        begin
          inhibit_q[n] <= 1'b1;
        end
        else if (!action_range_in[n])
        begin
          inhibit_q[n] <= 1'b0;
        end
      end
    end
  end

  // Combines every path into the qualified event state.
  always_comb
  begin
    for (int n = 0; n < NCH; n++)
    begin
      automatic logic [4:0]  t  = ccfg[n].output_type_select;
      automatic logic [1:0]  s  = ccfg[n].power_on_suppress;
      automatic logic [13:0] d  = ccfg[n].assert_delay;
      automatic logic        lim = (t >= OT_LIMIT_LO) && (t <= OT_LIMIT_HI);
      automatic logic        dly;
      // Delay then assert; off passes through
      dly = (d == 14'h0000) ? action_range_in[n] : (action_range_in[n] && elapsed_q[n] >= d);
      next_asserted[n] = 1'b0;
      if (lim)
      begin
        next_asserted[n] = dly & ~(inhibit_q[n] & (s == SUP_RUN || s == SUP_SETPOINT));
        if (range_overflow_in[n])
        begin
          // Setting 3 forces off; others force on
          next_asserted[n] = (s != SUP_OVF_OFF);
        end
      end
      else if (t == OT_LOGIC)
      begin
        // Logic on first six; timer on last two
        next_asserted[n] = (n < NLOGIC) ? logic_val[n] : pulse_q[1'(n - TC_FIRST)];
      end
      else if (t != OT_NONE && t != 5'h00)
      begin
        next_asserted[n] = action_range_in[n];
      end
      if ((lim || t == OT_POS_HI || t == OT_POS_LO) && !run_q)
      begin
        next_asserted[n] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output drive.

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      asserted       <= {NCH{1'b0}};
      output_pin_out <= {NCH{1'b0}};
      run_state_out  <= 1'b0;
    end
    else
    begin
      asserted      <= next_asserted;
      run_state_out <= run_q;
      for (int n = 0; n < NCH; n++)
      begin
        output_pin_out[n] <= next_asserted[n] ^ ccfg[n].output_polarity;
      end
    end
  end

endmodule
`default_nettype wire

// ### sim/eoq_qualifier_assertions.sv
// Checker for the qualifier's APB answers, refused writes and run switching.
// Assumes a bind to eoq_qualifier; it sees only that module's ports.
`default_nettype none
module eoq_chk import eoq_pkg::*; (
  input wire logic           ref_clk_in, rst_n_in, psel_in, penable_in, pwrite_in,
  input wire logic           pready_out, pslverr_out, run_state_out,
  input wire logic [7:0]     paddr_in, output_pin_out,
  input wire logic [31:0]    pwdata_in,
  input wire logic [NDI-1:0] contact_input_in
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Aligned write access cycles to the logic and configuration blocks.
  wire logic lw = pready_out && pwrite_in && paddr_in[7:5] == BLK_LOGIC && paddr_in[1:0] == 2'h0;
  wire logic cw = pready_out && pwrite_in && paddr_in[7:5] == BLK_CFG && paddr_in[1:0] == 2'h0;
  property p_ans; psel_in && !penable_in |=> pready_out; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; pready_out |=> !pready_out; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_dly; cw && pwdata_in[21:8] > DELAY_MAX |-> pslverr_out; endproperty
  a_dly: assert property (p_dly) else $error("long delay kept");
  property p_pre; lw && pwdata_in[28:16] > COUNT_MAX |-> pslverr_out; endproperty
  a_pre: assert property (p_pre) else $error("big preset kept");
  property p_src; lw && pwdata_in[6:2] > SRC_DI_HI |-> pslverr_out; endproperty
  a_src: assert property (p_src) else $error("bad source kept");
  property p_fn; lw && pwdata_in[1:0] == 2'h3 |-> pslverr_out; endproperty
  a_fn: assert property (p_fn) else $error("bad function kept");
  property p_tog; lw && pwdata_in[13:12] == CND_TOGGLE
    && pwdata_in[6:2] inside {[SRC_TS_LO:SRC_TS_HI]} |-> pslverr_out; endproperty
  a_tog: assert property (p_tog) else $error("toggle on time signal kept");
  property p_run; $rose(contact_input_in[0]) |-> ##2 $changed(run_state_out); endproperty
  a_run: assert property (p_run) else $error("run not switched");
  c_err: cover property (pready_out && pslverr_out);
  c_run: cover property ($rose(run_state_out));
  c_pulse: cover property ($fell(output_pin_out[6]));
endmodule
`default_nettype wire

// ### sim/eoq_field_model.sv
// Field side: contact switches that hold each new level a minimum time.
// Assumes the bench asks for levels on want_in, synchronous to clk_in.
`default_nettype none
module eoq_field_model #(parameter int HOLD = 2) (
  input  wire logic       clk_in,      // Bench clock.
  input  wire logic [9:0] want_in,     // Levels the bench asks for.
  output logic      [9:0] contact_out  // Levels at the contacts.
);
  int held = 0;  // Cycles since the last change.
  initial contact_out = '0;
  always @(posedge clk_in)
    if (want_in != contact_out && held >= HOLD)
    begin
      contact_out <= want_in;
      held <= 0;
    end
    else held <= held + 1;
endmodule
`default_nettype wire

// ### sim/eoq_qualifier_tb_top.sv
// Bench: APB reads, refused writes, run switch, logic, delay, overflow, timer.
// Assumes the checker and field model are compiled before it.
`default_nettype none
module eoq_qualifier_tb_top import eoq_pkg::*;;
  timeunit 1ns; timeprecision 1ps;
  localparam int T = 20;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, spc = 0, er, prdy, perr, run;
  logic [7:0] pa = 0, ts = 0, ar = 0, ovf = 0, pin;
  logic [9:0] want = 0, di;
  logic [31:0] pwd = 0, prd, rd;
  logic [15:0] lf = 16'h0021;
  int error_cnt = 0, num_checks = 0, n;
  logic [7:0] ba[8] = '{8'h00, 8'h80, 8'h22, 8'h20, 8'h40, 8'h40, 8'h40, 8'h40};
  logic [31:0] bd[8] = '{0, 0, 0, 32'h271002, 32'h13890000, 32'h4c, 32'h3, 32'h2004};
  eoq_field_model #(.HOLD(T / 10)) u_eoq_field_model (.clk_in(clk), .want_in(want),
    .contact_out(di));
  eoq_qualifier #(.TICK_CYCLES(T)) u_eoq_qualifier (.ref_clk_in(clk), .rst_n_in(rst_n),
    .paddr_in(pa), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .contact_input_in(di),
    .program_time_signal_in(ts), .action_range_in(ar), .range_overflow_in(ovf),
    .setpoint_change_in(spc), .output_pin_out(pin), .run_state_out(run));
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic lg(logic [1:0] f, logic a, logic b);
    return f == FN_AND ? a & b : f == FN_OR ? a | b : a ^ b;
  endfunction
  task automatic chk(logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd; er = perr;
    psel <= 0; pen <= 0;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial forever #10 clk = ~clk;
  initial begin #100000; error_cnt++; give_verdict; end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    apb(0, 8'h00, 0); chk(rd, 0);
    apb(0, 8'h20, 0); chk(rd, 32'(CCFG_RESET));
    foreach (ba[i]) begin apb(1, ba[i], bd[i]); chk(er, 1); end
    apb(0, 8'h40, 0); chk(rd, 0);
    want[0] <= 1; repeat (6) @(posedge clk); chk(run, 1);
    apb(0, 8'h00, 0); chk(rd[18:0], 19'h40001);
    $display("basics end");
    apb(1, 8'h20, 32'hc);
    for (int f = 0; f < 3; f++)
    begin
      apb(1, 8'h40, 32'h4104 | f);
      repeat (4) begin lf = nx(lf); ts <= lf[7:0]; repeat (2) @(posedge clk);
        chk(pin[0], lg(f[1:0], ts[0], ~ts[1])); end
    end
    $display("logic end");
    apb(1, 8'h2c, 32'h202); apb(1, 8'h30, 32'hc2);
    ar <= 8'h18; repeat (2) @(posedge clk); chk(pin[4], 1);
    repeat (T / 2) @(posedge clk); chk(pin[3], 0);
    repeat (2 * T) @(posedge clk); chk(pin[3], 1);
    ar <= 8'h10; ovf <= 8'h18; repeat (2) @(posedge clk);
    chk(pin[3], 1);
    chk(pin[4], 0);
    ovf <= 0; ar <= 0;
    // Setpoint pulse arms suppression; the range must be left and re-entered.
    apb(1, 8'h2c, 32'h82); spc <= 1; @(posedge clk); spc <= 0; ar <= 8'h08;
    repeat (3) @(posedge clk); chk(pin[3], 0);
    ar <= 0; @(posedge clk); ar <= 8'h08; repeat (2) @(posedge clk);
    chk(pin[3], 1);
    ar <= 0; $display("limit end");
    ts <= 0; apb(1, 8'h38, 32'hc); apb(1, 8'h58, 32'h1000c);
    ts <= 8'h04; n = 0;
    while (pin[6] !== 1'b1 && n < 3 * T) begin @(posedge clk); n++; end
    chk(n < 3 * T, 1);
    n = 0;
    while (pin[6] === 1'b1 && n < 3 * T) begin @(posedge clk); n++; end
    chk(n >= T && n <= T + 1, 1);
    // Counter with target two on the last output; the second rise fires it.
    ts <= 0; apb(1, 8'h3c, 32'hc); apb(1, 8'h5c, 32'h2000d);
    repeat (2) begin ts <= 8'h04; repeat (2) @(posedge clk); ts <= 0; repeat (2) @(posedge clk); end
    chk(pin[7], 1);
    $display("timer end");
    give_verdict;
  end
endmodule
bind eoq_qualifier eoq_chk u_eoq_chk (.ref_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
  .pready_out, .pslverr_out, .run_state_out, .paddr_in, .output_pin_out, .pwdata_in,
  .contact_input_in);
`default_nettype wire
